/* File: src/dual_scan_passive_panel_lcd_pkg.sv */
// Constants, register layout and state types for the dual-scan panel line pulse control.
package dual_scan_passive_panel_lcd_pkg;
  // Indexed I/O ports: the index port selects a register, the data port moves its value.
  localparam logic [15:0] INDEX_PORT = 16'h03c4;
  localparam logic [15:0] DATA_PORT  = 16'h03c5;
  // Register indices.
  localparam logic [7:0] IDX_SEQ_LP    = 8'h34;
  localparam logic [7:0] IDX_HEIGHT_HI = 8'h3e;
  localparam logic [7:0] IDX_HEIGHT_LO = 8'h3f;
  // Values after reset.
  localparam logic [7:0] RST_SEQ_LP = 8'h80;
  localparam logic [7:0] RST_HEIGHT = 8'h00;
  // Field positions of the sequence and line pulse control register.
  localparam int HW_SEQ_BIT = 7;
  localparam int WIDTH_BIT  = 6;
  localparam int ODD_LSB    = 4;
  localparam int EVEN_LSB   = 0;
  // Field positions of the height high and misc control register.
  localparam int OUT_SEL_BIT = 7;
  localparam int RSVD_BIT    = 6;
  localparam int GFLIP_BIT   = 5;
  localparam int VFLIP_BIT   = 4;
  localparam int FPD_BIT     = 3;
  localparam int FREE_BIT    = 2;
  // Line pulse widths in pixel clocks.
  localparam logic [5:0] LP_NARROW = 6'h10;
  localparam logic [5:0] LP_WIDE   = 6'h20;
  // Number of panel power steps in the sequence.
  localparam logic [2:0] POWER_STEPS = 3'h4;
  // Extra line pulse sequencer states.
  typedef enum logic [0:0] {EXTRA_IDLE, EXTRA_RUN} extra_state_t;
endpackage : dual_scan_passive_panel_lcd_pkg

/* File: src/line_pulse_gen.sv */
// Line pulse generator that holds its output high for a selectable number of pixel clocks.
`timescale 1ns/10ps
module line_pulse_gen (
  // Clock and reset.
  input  wire logic sys_clk,
  input  wire logic rst,
  // Request and width select.
  input  wire logic start,
  input  wire logic wide,
  // Pulse output, also the busy flag.
  output logic      pulse_q
);
  logic [5:0] cnt_q;  // Remaining high cycles minus one.

  // A start while idle loads the width; the pulse falls after the count runs out.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pulse_q <= 1'b0;
      cnt_q   <= 6'h00;
    end else if (start && !pulse_q) begin
      pulse_q <= 1'b1;
      cnt_q   <= (wide ? dual_scan_passive_panel_lcd_pkg::LP_WIDE : dual_scan_passive_panel_lcd_pkg::LP_NARROW) - 6'h01;
    end else if (pulse_q) begin
      if (cnt_q == 6'h00) begin
        pulse_q <= 1'b0;
      end else begin
        cnt_q <= cnt_q - 6'h01;
      end
    end
  end

  logic [5:0] hi_cnt_q;  // High cycles of the pulse now in progress, for the width check.

  // Checking logic: counts the cycles for which the pulse has been seen high.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      hi_cnt_q <= 6'h00;
    end else begin
      hi_cnt_q <= pulse_q ? hi_cnt_q + 6'h01 : 6'h00;
    end
  end

  // A finished pulse has lasted exactly the selected width.
  property p_width;
    @(posedge sys_clk) disable iff (rst)
      $fell(pulse_q) |-> hi_cnt_q == (wide ? 6'h20 : 6'h10);
  endproperty
  a_width: assert property (p_width) else $error("Line pulse width wrong.");
endmodule : line_pulse_gen

/* File: src/dual_scan_passive_panel_lcd_line_pulse_control.sv */
// Function
// - Top bit picks hardware or software power sequencing.
// - Line pulse lasts 16 or 32 pixel clocks.
// - Standard mode: 0-3 extra pulses odd frames.
// - Standard mode: 0-15 extra pulses even frames.
// - Virtual refresh: 4-bit count every frame.
// - Height is high bits 1:0 plus low byte.
// - Select bit routes display enable or AC drive.
// - Graphics flip bit clears after flip done.
// - Video flip bit clears after flip done.
// - Detect bit clears when frame pulse seen.
// - Free-running enable makes continuous line pulses.
// - Reset clears both height registers.
// - Index then data port reach registers.
// - Hardware power steps spaced 1/2/4/8 frames.
// - Virtual refresh enable picks per-frame behaviour.
`timescale 1ns/10ps
module dual_scan_passive_panel_lcd_line_pulse_control #(
  parameter int FREE_LINE_PERIOD = 800  // Pixel clocks between free-running line pulses.
) (
  // Clock and reset.
  input  wire logic       sys_clk,
  input  wire logic       rst,
  // Indexed I/O port from the host.
  input  wire logic [15:0] io_addr,
  input  wire logic        io_wr,
  input  wire logic        io_rd,
  input  wire logic [7:0]  io_wdata,
  output logic      [7:0]  io_rdata_q,
  // Panel timing from the display pipeline.
  input  wire logic        frame_pulse_in,
  input  wire logic        line_start_in,
  input  wire logic        last_line_done_in,
  input  wire logic        display_enable_in,
  input  wire logic        ac_drive_in,
  input  wire logic        virtual_refresh_enable,
  // Power sequencing controls.
  input  wire logic        panel_on_in,
  input  wire logic [1:0]  power_step_sel,
  input  wire logic [3:0]  sw_power_steps,
  // Panel side outputs.
  output logic             line_pulse,
  output logic             panel_shared_out_q,
  output logic [3:0]       power_steps_q,
  output logic             graphics_flip_q,
  output logic             video_flip_q,
  output logic [9:0]       panel_half_height_q
);
  logic [7:0] index_q;    // Selected register index.
  logic [7:0] seq_lp_q;   // Sequence and line pulse control.
  logic [7:0] hi_ctl_q;   // Height high bits and misc control.
  logic [7:0] height_lo_q;  // Height low byte.
  logic       odd_q;      // High during an odd frame.
  logic       data_wr;    // Host write to the data port.
  logic [3:0] extra_left_q;   // Extra pulses still owed.
  logic [3:0] extra_count;    // Extra pulses owed for this frame.
  logic [11:0] free_cnt_q;    // Free-running line period counter.
  logic       free_tick;      // Free-running line request.
  logic       normal_start;   // Ordinary line request.
  logic       gen_start;      // Request into the generator.
  logic [2:0] step_q;         // Power steps currently on.
  logic [3:0] frame_cnt_q;    // Frames since the last power step.
  dual_scan_passive_panel_lcd_pkg::extra_state_t extra_st_q;  // Extra pulse sequencer state.
  assign data_wr = io_wr && (io_addr == dual_scan_passive_panel_lcd_pkg::DATA_PORT);
  // Index port write selects the register for later data accesses.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      index_q <= 8'h00;
    end else if (io_wr && io_addr == dual_scan_passive_panel_lcd_pkg::INDEX_PORT) begin
      index_q <= io_wdata;
    end
  end
  // Plain control registers load from the data port.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      seq_lp_q    <= dual_scan_passive_panel_lcd_pkg::RST_SEQ_LP;
      height_lo_q <= dual_scan_passive_panel_lcd_pkg::RST_HEIGHT;
    end else if (data_wr) begin
      if (index_q == dual_scan_passive_panel_lcd_pkg::IDX_SEQ_LP) begin
        seq_lp_q <= io_wdata;
      end
      if (index_q == dual_scan_passive_panel_lcd_pkg::IDX_HEIGHT_LO) begin
        height_lo_q <= io_wdata;
      end
    end
  end
  // Height high register: request bits are set by software and cleared at frame pulse.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      hi_ctl_q <= dual_scan_passive_panel_lcd_pkg::RST_HEIGHT;
    end else begin
      if (frame_pulse_in) begin
        hi_ctl_q[dual_scan_passive_panel_lcd_pkg::GFLIP_BIT] <= 1'b0;
        hi_ctl_q[dual_scan_passive_panel_lcd_pkg::VFLIP_BIT] <= 1'b0;
        hi_ctl_q[dual_scan_passive_panel_lcd_pkg::FPD_BIT]   <= 1'b0;
      end
      if (data_wr && index_q == dual_scan_passive_panel_lcd_pkg::IDX_HEIGHT_HI) begin
        // A set arriving with the clear wins, so no request is lost; a pending bit
        // that is not written again is still cleared, because its flip has just run.
        hi_ctl_q[7]   <= io_wdata[7];
        hi_ctl_q[2:0] <= io_wdata[2:0];
        hi_ctl_q[5:3] <= (frame_pulse_in ? 3'b000 : hi_ctl_q[5:3]) | io_wdata[5:3];
        hi_ctl_q[dual_scan_passive_panel_lcd_pkg::RSVD_BIT] <= 1'b0;
      end
    end
  end
  // Read data for the host; unknown indices read as zero, reserved bit reads zero.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      io_rdata_q <= 8'h00;
    end else if (io_rd) begin
      if (io_addr == dual_scan_passive_panel_lcd_pkg::INDEX_PORT) begin
        io_rdata_q <= index_q;
      end else if (io_addr == dual_scan_passive_panel_lcd_pkg::DATA_PORT) begin
        unique case (index_q)
          dual_scan_passive_panel_lcd_pkg::IDX_SEQ_LP:    io_rdata_q <= seq_lp_q;
          dual_scan_passive_panel_lcd_pkg::IDX_HEIGHT_HI: io_rdata_q <= hi_ctl_q;
          dual_scan_passive_panel_lcd_pkg::IDX_HEIGHT_LO: io_rdata_q <= height_lo_q;
          default:                     io_rdata_q <= 8'h00;
        endcase
      end else begin
        io_rdata_q <= 8'h00;
      end
    end
  end
  // Half height value and the shared panel output select.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      panel_half_height_q <= 10'h000;
      panel_shared_out_q  <= 1'b0;
    end else begin
      panel_half_height_q <= {hi_ctl_q[1:0], height_lo_q};
      panel_shared_out_q  <= hi_ctl_q[dual_scan_passive_panel_lcd_pkg::OUT_SEL_BIT]
                             ? ac_drive_in : display_enable_in;
    end
  end
  // Flip strobes fire at the frame boundary for each pending request.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      graphics_flip_q <= 1'b0;
      video_flip_q    <= 1'b0;
    end else begin
      graphics_flip_q <= frame_pulse_in && hi_ctl_q[dual_scan_passive_panel_lcd_pkg::GFLIP_BIT];
      video_flip_q    <= frame_pulse_in && hi_ctl_q[dual_scan_passive_panel_lcd_pkg::VFLIP_BIT];
    end
  end
  // Frame parity tracks odd and even frames for the extra pulse count.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      odd_q <= 1'b0;
    end else if (frame_pulse_in) begin
      odd_q <= !odd_q;
    end
  end
  // Extra pulse count: per frame in virtual refresh, odd/even otherwise.
  assign extra_count = (virtual_refresh_enable || !odd_q)
                       ? seq_lp_q[dual_scan_passive_panel_lcd_pkg::EVEN_LSB +: 4]
                       : {2'b00, seq_lp_q[dual_scan_passive_panel_lcd_pkg::ODD_LSB +: 2]};
  // Free-running line period counter, active only while enabled.
  always_ff @(posedge sys_clk) begin
    if (rst || !hi_ctl_q[dual_scan_passive_panel_lcd_pkg::FREE_BIT]) begin
      free_cnt_q <= 12'h000;
    end else if (free_tick) begin
      free_cnt_q <= 12'h000;
    end else begin
      free_cnt_q <= free_cnt_q + 12'h001;
    end
  end
  assign free_tick = hi_ctl_q[dual_scan_passive_panel_lcd_pkg::FREE_BIT]
                     && (free_cnt_q == 12'(FREE_LINE_PERIOD - 1));
  assign normal_start = hi_ctl_q[dual_scan_passive_panel_lcd_pkg::FREE_BIT] ? free_tick : line_start_in;
  // Ordinary lines take priority; an extra pulse waits for an idle generator.
  assign gen_start = normal_start
                     || (extra_st_q == dual_scan_passive_panel_lcd_pkg::EXTRA_RUN && !line_pulse);
  // Extra pulse sequencer: armed by the last active line, one pulse per idle slot.
  always_ff @(posedge sys_clk) begin
    if (rst || frame_pulse_in) begin
      extra_st_q   <= dual_scan_passive_panel_lcd_pkg::EXTRA_IDLE;
      extra_left_q <= 4'h0;
    end else begin
      unique case (extra_st_q)
        dual_scan_passive_panel_lcd_pkg::EXTRA_IDLE: begin
          if (last_line_done_in && extra_count != 4'h0) begin
            extra_st_q   <= dual_scan_passive_panel_lcd_pkg::EXTRA_RUN;
            extra_left_q <= extra_count;
          end
        end
        dual_scan_passive_panel_lcd_pkg::EXTRA_RUN: begin
          if (!normal_start && !line_pulse) begin
            extra_left_q <= extra_left_q - 4'h1;
            if (extra_left_q == 4'h1) begin
              extra_st_q <= dual_scan_passive_panel_lcd_pkg::EXTRA_IDLE;
            end
          end
        end
      endcase
    end
  end
  // Line pulse generator with the selected width.
  line_pulse_gen u_gen (
    .sys_clk (sys_clk),
    .rst     (rst),
    .start   (gen_start),
    .wide    (seq_lp_q[dual_scan_passive_panel_lcd_pkg::WIDTH_BIT]),
    .pulse_q (line_pulse)
  );
  // Power steps: hardware walks one step per 1/2/4/8 frames, software drives directly.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      step_q        <= 3'h0;
      frame_cnt_q   <= 4'h0;
      power_steps_q <= 4'h0;
    end else if (seq_lp_q[dual_scan_passive_panel_lcd_pkg::HW_SEQ_BIT]) begin
      power_steps_q <= 4'((5'h01 << step_q) - 5'h01);
      if (frame_pulse_in) begin
        if (frame_cnt_q + 4'h1 >= (4'h1 << power_step_sel)) begin
          frame_cnt_q <= 4'h0;
          if (panel_on_in && step_q != dual_scan_passive_panel_lcd_pkg::POWER_STEPS) begin
            step_q <= step_q + 3'h1;
          end else if (!panel_on_in && step_q != 3'h0) begin
            step_q <= step_q - 3'h1;
          end
        end else begin
          frame_cnt_q <= frame_cnt_q + 4'h1;
        end
      end
    end else begin
      power_steps_q <= sw_power_steps;
      frame_cnt_q   <= 4'h0;
    end
  end
  // Checks of this block; the pulse width itself is checked inside the generator.
  sequence s_gflip_req;  // Frame pulse with a pending graphics flip and no host write.
    frame_pulse_in && hi_ctl_q[dual_scan_passive_panel_lcd_pkg::GFLIP_BIT] && !data_wr;
  endsequence
  sequence s_gflip_done;  // Strobe out and bit cleared one cycle later.
    ##1 graphics_flip_q && !hi_ctl_q[dual_scan_passive_panel_lcd_pkg::GFLIP_BIT];
  endsequence
  property p_reset_vals;
    @(posedge sys_clk) disable iff (rst)
      $fell(rst) |-> (seq_lp_q == 8'h80 && hi_ctl_q == 8'h00 && height_lo_q == 8'h00);
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("Bad reset values.");
  property p_odd;
    @(posedge sys_clk) disable iff (rst || frame_pulse_in)
      (extra_st_q == dual_scan_passive_panel_lcd_pkg::EXTRA_IDLE && last_line_done_in && odd_q
       && !virtual_refresh_enable && seq_lp_q[5:4] != 2'b00)
      |=> extra_left_q == {2'b00, $past(seq_lp_q[5:4])};
  endproperty
  a_odd: assert property (p_odd) else $error("Odd frame extra count wrong.");
  property p_even;
    @(posedge sys_clk) disable iff (rst || frame_pulse_in)
      (extra_st_q == dual_scan_passive_panel_lcd_pkg::EXTRA_IDLE && last_line_done_in && !odd_q
       && !virtual_refresh_enable && seq_lp_q[3:0] != 4'h0)
      |=> extra_left_q == $past(seq_lp_q[3:0]);
  endproperty
  a_even: assert property (p_even) else $error("Even frame extra count wrong.");
  property p_virt;
    @(posedge sys_clk) disable iff (rst || frame_pulse_in)
      (extra_st_q == dual_scan_passive_panel_lcd_pkg::EXTRA_IDLE && last_line_done_in
       && virtual_refresh_enable && seq_lp_q[3:0] != 4'h0)
      |=> extra_left_q == $past(seq_lp_q[3:0]);
  endproperty
  a_virt: assert property (p_virt) else $error("Virtual refresh count wrong.");
  property p_height;
    @(posedge sys_clk) disable iff (rst)
      ##1 panel_half_height_q == {$past(hi_ctl_q[1:0]), $past(height_lo_q)};
  endproperty
  a_height: assert property (p_height) else $error("Half height wrong.");
  property p_out_sel;
    @(posedge sys_clk) disable iff (rst)
      hi_ctl_q[7] ##1 hi_ctl_q[7] |-> panel_shared_out_q == $past(ac_drive_in);
  endproperty
  a_out_sel: assert property (p_out_sel) else $error("Shared output select wrong.");
  property p_gflip;
    @(posedge sys_clk) disable iff (rst) s_gflip_req |-> s_gflip_done;
  endproperty
  a_gflip: assert property (p_gflip) else $error("Graphics flip not done.");
  property p_vflip;
    @(posedge sys_clk) disable iff (rst)
      frame_pulse_in && hi_ctl_q[4] && !data_wr |=> video_flip_q && !hi_ctl_q[4];
  endproperty
  a_vflip: assert property (p_vflip) else $error("Video flip not done.");
  property p_fpd;
    @(posedge sys_clk) disable iff (rst) frame_pulse_in && !data_wr |=> !hi_ctl_q[3];
  endproperty
  a_fpd: assert property (p_fpd) else $error("Frame detect bit not cleared.");
  property p_free;
    @(posedge sys_clk) disable iff (rst) free_tick && !line_pulse |=> line_pulse;
  endproperty
  a_free: assert property (p_free) else $error("Free-running pulse missing.");
  property p_step;
    @(posedge sys_clk) disable iff (rst)
      seq_lp_q[7] && $changed(step_q) |-> $past(frame_pulse_in);
  endproperty
  a_step: assert property (p_step) else $error("Power step off frame boundary.");
endmodule : dual_scan_passive_panel_lcd_line_pulse_control

/* File: dv/dual_scan_passive_panel_panel_model.sv */
// Behavioural passive panel that measures the line pulses it receives.
`timescale 1ns/10ps
module dual_scan_passive_panel_panel_model (
  // Clock.
  input  wire logic       sys_clk,
  // Signals arriving at the panel.
  input  wire logic       line_pulse,
  input  wire logic       panel_shared_out_q,
  input  wire logic [3:0] power_steps_q,
  // Measurements for the bench.
  output int              pulses,
  output int              width
);
  int run = 0;  // Length of the pulse now in progress.
  int cnt = 0;  // Number of finished pulses.
  int wid = 0;  // Width of the last finished pulse.
  assign pulses = cnt;
  assign width  = wid;
  // A pulse is counted when it ends, so that its whole width is known.
  always @(posedge sys_clk) begin
    if (line_pulse === 1'b1) begin
      run++;
    end else begin
      if (run > 0) begin
        cnt++;
        wid = run;
      end
      run = 0;
    end
  end
endmodule : dual_scan_passive_panel_panel_model

/* File: dv/tb.sv */
// Self-checking bench for the dual-scan panel line pulse control.
`timescale 1ns/10ps
module tb;
  logic        sys_clk = 1'b0;
  logic        rst = 1'b1;
  logic [15:0] io_addr = 16'h0000;
  logic        io_wr = 1'b0;
  logic        io_rd = 1'b0;
  logic [7:0]  io_wdata = 8'h00;
  logic [7:0]  io_rdata_q;
  logic        frame_pulse_in = 1'b0;
  logic        line_start_in = 1'b0;
  logic        last_line_done_in = 1'b0;
  logic        display_enable_in = 1'b0;
  logic        ac_drive_in = 1'b0;
  logic        virtual_refresh_enable = 1'b0;
  logic        panel_on_in = 1'b0;
  logic [1:0]  power_step_sel = 2'h0;
  logic [3:0]  sw_power_steps = 4'h0;
  logic        line_pulse, panel_shared_out_q, graphics_flip_q, video_flip_q;
  logic [3:0]  power_steps_q;
  logic [9:0]  panel_half_height_q;
  logic [7:0]  r;
  int          pulses, width, p0, exp_n;
  int          n_mismatch = 0;
  int          tests_run = 0;
  int          cycles = 0;
  int          nfr = 0;
  int          gf_n = 0;
  int          vf_n = 0;
  integer      seed = 32'ha9e5;

  // Pixel clock at 50 MHz.
  always #10 sys_clk = ~sys_clk;

  dual_scan_passive_panel_lcd_line_pulse_control #(.FREE_LINE_PERIOD(40)) dual_scan_passive_panel_lcd_line_pulse_control_inst (
    .sys_clk, .rst, .io_addr, .io_wr, .io_rd, .io_wdata, .io_rdata_q, .frame_pulse_in,
    .line_start_in, .last_line_done_in, .display_enable_in, .ac_drive_in,
    .virtual_refresh_enable, .panel_on_in, .power_step_sel, .sw_power_steps, .line_pulse,
    .panel_shared_out_q, .power_steps_q, .graphics_flip_q, .video_flip_q,
    .panel_half_height_q);

  dual_scan_passive_panel_panel_model dual_scan_passive_panel_panel_model_inst (
    .sys_clk, .line_pulse, .panel_shared_out_q, .power_steps_q, .pulses, .width);

  // Counts flip pulses and cuts a hang short.
  always @(posedge sys_clk) begin
    cycles++;
    if (graphics_flip_q === 1'b1) gf_n++;
    if (video_flip_q === 1'b1) vf_n++;
    if (cycles == 20000) begin
      $display("Error at %0t: timeout", $time);
      n_mismatch++;
      final_report();
    end
  end

  // Prints the counts and the verdict, then ends the run.
  task final_report;
    $display("Comparisons %0d, mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : final_report

  // Counts one comparison and reports it when it fails.
  task chk(input bit ok, input string m);
    tests_run++;
    if (!ok) begin
      n_mismatch++;
      $display("Error at %0t: %s", $time, m);
    end
  endtask : chk

  // One host I/O cycle with a single-cycle strobe.
  task io(input logic [15:0] a, input logic [7:0] d, input bit w);
    @(negedge sys_clk);
    io_addr = a;
    io_wdata = d;
    io_wr = w;
    io_rd = !w;
    @(negedge sys_clk);
    io_wr = 1'b0;
    io_rd = 1'b0;
  endtask : io

  // Indexed register write: index first, then data.
  task wr(input logic [7:0] i, input logic [7:0] d);
    io(dual_scan_passive_panel_lcd_pkg::INDEX_PORT, i, 1'b1);
    io(dual_scan_passive_panel_lcd_pkg::DATA_PORT, d, 1'b1);
  endtask : wr

  // Indexed register read compared with the expected value.
  task rd(input logic [7:0] i, input logic [7:0] e);
    io(dual_scan_passive_panel_lcd_pkg::INDEX_PORT, i, 1'b1);
    io(dual_scan_passive_panel_lcd_pkg::DATA_PORT, 8'h00, 1'b0);
    chk(io_rdata_q === e, "register read");
  endtask : rd

  // Waits a number of falling edges.
  task clk(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : clk

  // One frame boundary pulse; the bench counts it in nfr to track the frame parity.
  task frame;
    @(negedge sys_clk);
    frame_pulse_in = 1'b1;
    nfr++;
    @(negedge sys_clk);
    frame_pulse_in = 1'b0;
  endtask : frame

  // Main sequence of scenarios.
  initial begin
    clk(10);
    rst = 1'b0;
    rd(dual_scan_passive_panel_lcd_pkg::IDX_SEQ_LP, 8'h80);
    rd(dual_scan_passive_panel_lcd_pkg::IDX_HEIGHT_HI, 8'h00);
    rd(dual_scan_passive_panel_lcd_pkg::IDX_HEIGHT_LO, 8'h00);
    wr(8'h35, 8'hff);
    rd(8'h35, 8'h00);
    wr(dual_scan_passive_panel_lcd_pkg::IDX_HEIGHT_HI, 8'h43);
    rd(dual_scan_passive_panel_lcd_pkg::IDX_HEIGHT_HI, 8'h03);
    r = 8'($random(seed)) & 8'hfe;
    wr(dual_scan_passive_panel_lcd_pkg::IDX_HEIGHT_LO, r);
    rd(dual_scan_passive_panel_lcd_pkg::IDX_HEIGHT_LO, r);
    chk(panel_half_height_q === {2'b11, r}, "height");
    // The shared output follows the selected source one cycle later.
    for (int s = 0; s < 2; s++) begin
      wr(dual_scan_passive_panel_lcd_pkg::IDX_HEIGHT_HI, {s[0], 7'h03});
      repeat (8) begin
        display_enable_in = 1'($random(seed));
        ac_drive_in = 1'($random(seed));
        @(negedge sys_clk);
        chk(panel_shared_out_q === (s ? ac_drive_in : display_enable_in), "shared");
      end
    end
    // Request bits clear at the frame boundary, flips only when asked for.
    wr(dual_scan_passive_panel_lcd_pkg::IDX_HEIGHT_HI, 8'h03);
    frame();
    clk(3);
    chk(gf_n == 0 && vf_n == 0, "unrequested flip");
    wr(dual_scan_passive_panel_lcd_pkg::IDX_HEIGHT_HI, 8'h3b);
    rd(dual_scan_passive_panel_lcd_pkg::IDX_HEIGHT_HI, 8'h3b);
    frame();
    clk(3);
    chk(gf_n == 1 && vf_n == 1, "flip pulses");
    rd(dual_scan_passive_panel_lcd_pkg::IDX_HEIGHT_HI, 8'h03);
    // Both line pulse widths.
    for (int w = 0; w < 2; w++) begin
      wr(dual_scan_passive_panel_lcd_pkg::IDX_SEQ_LP, {1'b1, w[0], 6'h00});
      line_start_in = 1'b1;
      clk(1);
      line_start_in = 1'b0;
      clk(40);
      chk(width == (16 << w), "line pulse width");
    end
    // Extra pulses in standard and virtual refresh frames.
    for (int i = 0; i < 6; i++) begin
      r = 8'($random(seed));
      wr(dual_scan_passive_panel_lcd_pkg::IDX_SEQ_LP, r);
      virtual_refresh_enable = (i > 2);
      frame();
      exp_n = (i > 2 || nfr % 2 == 0) ? int'(r[3:0]) : int'(r[5:4]);
      p0 = pulses;
      last_line_done_in = 1'b1;
      clk(1);
      last_line_done_in = 1'b0;
      clk(exp_n * ((16 << r[6]) + 1) + 40);
      chk(pulses - p0 == exp_n, "extra count");
      if (exp_n > 0) chk(width == (16 << r[6]), "extra width");
    end
    // Free-running pulses start and stop with their enable bit.
    wr(dual_scan_passive_panel_lcd_pkg::IDX_HEIGHT_HI, 8'h07);
    p0 = pulses;
    clk(400);
    chk(pulses - p0 >= 8 && pulses - p0 <= 11, "free running");
    wr(dual_scan_passive_panel_lcd_pkg::IDX_HEIGHT_HI, 8'h03);
    clk(50);
    p0 = pulses;
    clk(200);
    chk(pulses == p0, "free running stopped");
    // Hardware power sequencing at every frame spacing.
    wr(dual_scan_passive_panel_lcd_pkg::IDX_SEQ_LP, 8'h80);
    for (int s = 0; s < 4; s++) begin
      power_step_sel = s[1:0];
      panel_on_in = 1'b1;
      repeat (2 << s) frame();
      clk(3);
      chk(power_steps_q === 4'h3, "power step spacing");
      repeat (2 << s) frame();
      clk(3);
      chk(power_steps_q === 4'hf, "power up");
      panel_on_in = 1'b0;
      repeat (4 << s) frame();
      clk(3);
      chk(power_steps_q === 4'h0, "power down");
    end
    wr(dual_scan_passive_panel_lcd_pkg::IDX_SEQ_LP, 8'h00);
    sw_power_steps = 4'($random(seed));
    clk(3);
    chk(power_steps_q === sw_power_steps, "software power");
    final_report();
  end
endmodule : tb
